// >>> lapm_top.sv
// Line alarm and performance monitor: alarm flags and saturating
// second-based and event counters for a DSL loop and an E1 line.
// Assumes all status inputs are synchronous to pclk; event inputs are
// one-cycle pulses, condition inputs are levels.
//
// Summary of operation
// - Count DSL unavailable second for each second with loop in loss of sync.
// - Count DSL severely errored second when a second holds 150+ CRC-6 errors.
// - Count DSL errored second when a second holds any CRC-6 error.
// - With CRC4 on, 832+ E1 CRC errors in a second make it severely errored.
// - With CRC4 off, 2048+ bipolar violations in a second make it severely errored.
// - LOS, LOF, AIS, RAI or slip in a second also make it E1 severely errored.
// - With CRC4 on, any E1 CRC error in a second makes it errored.
// - With CRC4 off, any bipolar violation in a second makes it errored.
// - LOS, LOF, AIS, RAI or slip in a second also make it E1 errored.
// - Count E1 unavailable seconds while the line is unavailable through errors.
// - Raise DSL loss-of-sync alarm while the transceiver reports sync lost.
// - Raise primary clock loss alarm while the clock is absent.
// - Raise remote link alarm while far-end user interface is inactive.
// - Raise local user link alarm while local user interface is inactive.
// - Raise E1 loss-of-frame alarm while frame alignment is missing.
// - Raise E1 AIS alarm while AIS is received.
// - Raise far-end yellow alarm while yellow alarm is received.
// - Count each received bipolar violation.
// - Count DSL and E1 CRC errors separately, readable by software.
`timescale 1ns/10ps
`default_nettype none

module lapm_top #(
   parameter int unsigned SECOND_CYCLES = lapm_pkg::SECOND_CYCLES
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic primary_clock_present, // Primary clock detected
   input wire logic remote_ui_inactive, // Far end reports its user side down
   input wire logic local_ui_inactive, // Local terminal side down
   input wire logic dsl_sync_lost, // Loop transceiver lost sync
   input wire logic dsl_crc_error, // Pulse per DSL CRC-6 error
   input wire logic e1_los, // E1 loss of signal
   input wire logic e1_lof, // E1 loss of frame alignment
   input wire logic e1_ais, // E1 alarm indication signal
   input wire logic e1_rai, // E1 remote alarm indication
   input wire logic e1_yellow, // E1 yellow alarm received
   input wire logic e1_slip, // Pulse per controlled slip
   input wire logic e1_bpv, // Pulse per bipolar violation
   input wire logic e1_crc_error, // Pulse per E1 CRC error
   output logic primary_clock_loss_alarm, // Clock missing
   output logic remote_link_alarm, // Far-end user side inactive
   output logic local_user_link_alarm, // Local user side inactive
   output logic dsl_loss_of_sync_alarm, // Loop out of sync
   output logic e1_loss_of_frame_alarm, // E1 out of frame
   output logic e1_ais_alarm, // E1 AIS received
   output logic far_end_yellow_alarm, // E1 yellow alarm
   output logic second_strobe // One-cycle pulse per second
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] sat_inc16(input logic [15:0] v);
      sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : sat_inc16

   function automatic logic [11:0] sat_add12(input logic [11:0] v, input logic e);
      sat_add12 = (e && v != 12'hFFF) ? v + 12'h001 : v;
   endfunction : sat_add12

   // ------------------------------------------------------------------
   // One-second timebase
   // ------------------------------------------------------------------
   logic [31:0] sec_cnt_q;
   logic sec_tick;

   assign sec_tick = ce && (sec_cnt_q == 32'(SECOND_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_strobe <= 1'b0;
      end else if (ce) begin
         second_strobe <= sec_tick;
      end
   end

   // ------------------------------------------------------------------
   // Alarm flags
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_clock_loss_alarm <= 1'b0;
         remote_link_alarm <= 1'b0;
         local_user_link_alarm <= 1'b0;
         dsl_loss_of_sync_alarm <= 1'b0;
         e1_loss_of_frame_alarm <= 1'b0;
         e1_ais_alarm <= 1'b0;
         far_end_yellow_alarm <= 1'b0;
      end else if (ce) begin
         primary_clock_loss_alarm <= !primary_clock_present;
         remote_link_alarm <= remote_ui_inactive;
         local_user_link_alarm <= local_ui_inactive;
         dsl_loss_of_sync_alarm <= dsl_sync_lost;
         e1_loss_of_frame_alarm <= e1_lof;
         e1_ais_alarm <= e1_ais;
         far_end_yellow_alarm <= e1_yellow;
      end
   end

   // ------------------------------------------------------------------
   // Per-second tallies
   // ------------------------------------------------------------------
   // The event of the strobe cycle is folded into the totals so it is
   // judged in the closing second rather than lost.
   logic [11:0] dsl_crc_sec_q, e1_crc_sec_q, e1_bpv_sec_q;
   logic dsl_los_sec_q, e1_cond_sec_q;
   logic [11:0] dsl_crc_now, e1_crc_now, e1_bpv_now;
   logic dsl_los_now, e1_cond_now, crc4_q;
   logic dsl_es, dsl_ses, e1_es, e1_ses;

   assign dsl_crc_now = sat_add12(dsl_crc_sec_q, dsl_crc_error);
   assign e1_crc_now = sat_add12(e1_crc_sec_q, e1_crc_error);
   assign e1_bpv_now = sat_add12(e1_bpv_sec_q, e1_bpv);
   assign dsl_los_now = dsl_los_sec_q || dsl_sync_lost;
   assign e1_cond_now = e1_cond_sec_q || e1_los || e1_lof || e1_ais || e1_rai || e1_slip;
   assign dsl_es = dsl_crc_now != 12'h000;
   assign dsl_ses = dsl_crc_now >= lapm_pkg::DSL_SES_CRC_MIN;
   assign e1_es = e1_cond_now
      || (crc4_q ? e1_crc_now != 12'h000
                 : e1_bpv_now != 12'h000);
   assign e1_ses = e1_cond_now
      || (crc4_q ? e1_crc_now >= lapm_pkg::E1_SES_CRC_MIN
                 : e1_bpv_now >= lapm_pkg::E1_SES_BPV_MIN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsl_crc_sec_q <= 12'h000;
         e1_crc_sec_q <= 12'h000;
         e1_bpv_sec_q <= 12'h000;
         dsl_los_sec_q <= 1'b0;
         e1_cond_sec_q <= 1'b0;
      end else if (ce) begin
         if (sec_tick) begin
            dsl_crc_sec_q <= 12'h000;
            e1_crc_sec_q <= 12'h000;
            e1_bpv_sec_q <= 12'h000;
            dsl_los_sec_q <= 1'b0;
            e1_cond_sec_q <= 1'b0;
         end else begin
            dsl_crc_sec_q <= dsl_crc_now;
            e1_crc_sec_q <= e1_crc_now;
            e1_bpv_sec_q <= e1_bpv_now;
            dsl_los_sec_q <= dsl_los_now;
            e1_cond_sec_q <= e1_cond_now;
         end
      end
   end

   // ------------------------------------------------------------------
   // E1 availability
   // ------------------------------------------------------------------
   // Ten consecutive severely errored seconds enter the unavailable
   // state, ten consecutive seconds that are not severely errored leave it.
   logic e1_unavail_q;
   logic [3:0] e1_run_q;
   logic e1_run_done, e1_enter_unavail;

   assign e1_run_done = (e1_run_q + 4'h1) == lapm_pkg::E1_UNAVAIL_RUN;
   assign e1_enter_unavail = !e1_unavail_q && e1_ses && e1_run_done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e1_unavail_q <= 1'b0;
         e1_run_q <= 4'h0;
      end else if (sec_tick) begin
         // A second that matches the present state breaks the run
         if (e1_unavail_q == e1_ses) begin
            e1_run_q <= 4'h0;
         end else if (e1_run_done) begin
            e1_run_q <= 4'h0;
            e1_unavail_q <= !e1_unavail_q;
         end else begin
            e1_run_q <= e1_run_q + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------------
   logic [15:0] cnt_q [lapm_pkg::NUM_CNT];
   logic [lapm_pkg::NUM_CNT-1:0] cnt_inc;
   logic clear_cnt;

   always_comb begin
      cnt_inc = '0;
      cnt_inc[lapm_pkg::CNT_DSL_UAS] = sec_tick && dsl_los_now;
      cnt_inc[lapm_pkg::CNT_DSL_SES] = sec_tick && dsl_ses;
      cnt_inc[lapm_pkg::CNT_DSL_ES] = sec_tick && dsl_es;
      cnt_inc[lapm_pkg::CNT_DSL_CRC] = ce && dsl_crc_error;
      cnt_inc[lapm_pkg::CNT_E1_UAS] = sec_tick && (e1_unavail_q || e1_enter_unavail);
      cnt_inc[lapm_pkg::CNT_E1_SES] = sec_tick && e1_ses;
      cnt_inc[lapm_pkg::CNT_E1_ES] = sec_tick && e1_es;
      cnt_inc[lapm_pkg::CNT_E1_BPV] = ce && e1_bpv;
      cnt_inc[lapm_pkg::CNT_E1_CRC] = ce && e1_crc_error;
   end

   // A count arriving with the clear survives as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < lapm_pkg::NUM_CNT; i++) begin
            cnt_q[i] <= 16'h0000;
         end
      end else if (ce) begin
         for (int i = 0; i < lapm_pkg::NUM_CNT; i++) begin
            if (clear_cnt) begin
               cnt_q[i] <= {15'h0000, cnt_inc[i]};
            end else if (cnt_inc[i]) begin
               cnt_q[i] <= sat_inc16(cnt_q[i]);
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   // Ready is registered so every access phase takes two cycles.
   logic apb_last, addr_ok, is_cnt;
   logic [7:0] cnt_off;
   logic [31:0] rd_d;
   logic [lapm_pkg::NUM_ALM-1:0] alarm_vec;

   assign apb_last = ce && psel && penable && pready;
   assign is_cnt = paddr >= lapm_pkg::ADDR_CNT_BASE && paddr <= lapm_pkg::ADDR_CNT_LAST
      && paddr[1:0] == 2'b00;
   assign addr_ok = is_cnt || paddr == lapm_pkg::ADDR_CTRL || paddr == lapm_pkg::ADDR_ALARM;
   assign cnt_off = (paddr - lapm_pkg::ADDR_CNT_BASE) >> 2;
   assign clear_cnt = apb_last && pwrite && paddr == lapm_pkg::ADDR_CTRL
      && pwdata[lapm_pkg::CTRL_CLEAR_BIT];

   always_comb begin
      alarm_vec = '0;
      alarm_vec[lapm_pkg::ALM_CLK_LOSS] = primary_clock_loss_alarm;
      alarm_vec[lapm_pkg::ALM_REMOTE] = remote_link_alarm;
      alarm_vec[lapm_pkg::ALM_LOCAL] = local_user_link_alarm;
      alarm_vec[lapm_pkg::ALM_DSL_LOS] = dsl_loss_of_sync_alarm;
      alarm_vec[lapm_pkg::ALM_E1_LOF] = e1_loss_of_frame_alarm;
      alarm_vec[lapm_pkg::ALM_E1_AIS] = e1_ais_alarm;
      alarm_vec[lapm_pkg::ALM_E1_YEL] = far_end_yellow_alarm;
      alarm_vec[lapm_pkg::ALM_E1_UNAVAIL] = e1_unavail_q;
      rd_d = 32'h0000_0000;
      if (paddr == lapm_pkg::ADDR_CTRL) begin
         rd_d[lapm_pkg::CTRL_CRC4_BIT] = crc4_q;
      end else if (paddr == lapm_pkg::ADDR_ALARM) begin
         rd_d[lapm_pkg::NUM_ALM-1:0] = alarm_vec;
      end else if (is_cnt) begin
         rd_d[15:0] = cnt_q[cnt_off[3:0]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= !addr_ok;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc4_q <= lapm_pkg::CTRL_CRC4_RESET;
      end else if (apb_last && pwrite && paddr == lapm_pkg::ADDR_CTRL) begin
         crc4_q <= pwdata[lapm_pkg::CTRL_CRC4_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_dsl_uas_count: assert property (
      sec_tick && dsl_los_now && !clear_cnt && cnt_q[0] != 16'hFFFF
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
      else $error("DSL unavailable second not counted");

   chk_dsl_ses_thresh: assert property (
      sec_tick && !clear_cnt && cnt_q[1] != 16'hFFFF
      |=> cnt_q[1] == $past(cnt_q[1]) + {15'h0000, $past(dsl_crc_now) >= 12'h096})
      else $error("DSL severely errored second miscounted");

   chk_dsl_es_count: assert property (
      sec_tick && !clear_cnt && cnt_q[2] != 16'hFFFF
      |=> cnt_q[2] == $past(cnt_q[2]) + {15'h0000, $past(dsl_crc_now) != 12'h000})
      else $error("DSL errored second miscounted");

   chk_e1_ses_crc4: assert property (
      sec_tick && crc4_q && !e1_cond_now && e1_crc_now == 12'h33F |-> !e1_ses)
      else $error("E1 severely errored second below CRC threshold");

   chk_e1_ses_bpv: assert property (
      sec_tick && !crc4_q && e1_bpv_now >= 12'h800 && !clear_cnt && cnt_q[5] != 16'hFFFF
      |=> cnt_q[5] == $past(cnt_q[5]) + 16'h0001)
      else $error("E1 severely errored second missed on violations");

   chk_e1_cond_ses: assert property (
      sec_tick && e1_cond_sec_q && !clear_cnt && cnt_q[5] != 16'hFFFF && cnt_q[6] != 16'hFFFF
      |=> cnt_q[5] == $past(cnt_q[5]) + 16'h0001
         && cnt_q[6] == $past(cnt_q[6]) + 16'h0001)
      else $error("E1 condition did not mark the second");

   chk_e1_es_mode: assert property (
      sec_tick && !e1_cond_now && (crc4_q ? e1_crc_now == 12'h000 : e1_bpv_now == 12'h000)
      |-> !e1_es)
      else $error("E1 errored second without cause");

   chk_e1_uas_state: assert property (
      sec_tick && e1_unavail_q && !clear_cnt && cnt_q[4] != 16'hFFFF
      |=> cnt_q[4] == $past(cnt_q[4]) + 16'h0001)
      else $error("E1 unavailable second not counted");

   chk_alarm_follow: assert property (
      ce |=> dsl_loss_of_sync_alarm == $past(dsl_sync_lost)
         && primary_clock_loss_alarm == !$past(primary_clock_present)
         && remote_link_alarm == $past(remote_ui_inactive)
         && local_user_link_alarm == $past(local_ui_inactive)
         && e1_loss_of_frame_alarm == $past(e1_lof)
         && e1_ais_alarm == $past(e1_ais)
         && far_end_yellow_alarm == $past(e1_yellow))
      else $error("Alarm flag does not follow its input");

   chk_bpv_event: assert property (
      ce && e1_bpv && !clear_cnt && cnt_q[7] != 16'hFFFF |=> cnt_q[7] == $past(cnt_q[7]) + 16'h0001)
      else $error("Bipolar violation not counted");

   chk_crc_separate: assert property (
      ce && dsl_crc_error && !e1_crc_error && !clear_cnt && cnt_q[3] != 16'hFFFF
      |=> cnt_q[3] == $past(cnt_q[3]) + 16'h0001 && cnt_q[8] == $past(cnt_q[8]))
      else $error("CRC counts not kept apart");

   chk_tally_clear: assert property (
      sec_tick |=> dsl_crc_sec_q == 12'h000 && e1_bpv_sec_q == 12'h000 && second_strobe)
      else $error("Per-second tally not cleared at strobe");

   chk_counter_sat: assert property (
      ce && !clear_cnt |=> cnt_q[7] >= $past(cnt_q[7]) && cnt_q[3] >= $past(cnt_q[3])
         && cnt_q[8] >= $past(cnt_q[8]))
      else $error("Counter wrapped");

endmodule : lapm_top

`default_nettype wire

// >>> lapm_pkg.sv
// Package for the line alarm and performance monitor: register map,
// field positions, reset values and timing constants.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
package lapm_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam longint unsigned SECOND_NS = 64'h0000_0000_3B9A_CA00;
   localparam int unsigned SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

   // ------------------------------------------------------------------
   // Thresholds per one-second interval
   // ------------------------------------------------------------------
   localparam logic [11:0] DSL_SES_CRC_MIN = 12'h096;
   localparam logic [11:0] E1_SES_CRC_MIN = 12'h340;
   localparam logic [11:0] E1_SES_BPV_MIN = 12'h800;
   localparam logic [3:0] E1_UNAVAIL_RUN = 4'hA;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ALARM = 8'h04;
   localparam logic [7:0] ADDR_CNT_BASE = 8'h08;
   localparam int unsigned NUM_CNT = 9;
   localparam logic [7:0] ADDR_CNT_LAST = 8'h28;

   // Counter slots
   localparam int unsigned CNT_DSL_UAS = 0;
   localparam int unsigned CNT_DSL_SES = 1;
   localparam int unsigned CNT_DSL_ES = 2;
   localparam int unsigned CNT_DSL_CRC = 3;
   localparam int unsigned CNT_E1_UAS = 4;
   localparam int unsigned CNT_E1_SES = 5;
   localparam int unsigned CNT_E1_ES = 6;
   localparam int unsigned CNT_E1_BPV = 7;
   localparam int unsigned CNT_E1_CRC = 8;

   // Control fields
   localparam int unsigned CTRL_CRC4_BIT = 0;
   localparam int unsigned CTRL_CLEAR_BIT = 1;
   localparam logic CTRL_CRC4_RESET = 1'b1;

   // Alarm status fields
   localparam int unsigned ALM_CLK_LOSS = 0;
   localparam int unsigned ALM_REMOTE = 1;
   localparam int unsigned ALM_LOCAL = 2;
   localparam int unsigned ALM_DSL_LOS = 3;
   localparam int unsigned ALM_E1_LOF = 4;
   localparam int unsigned ALM_E1_AIS = 5;
   localparam int unsigned ALM_E1_YEL = 6;
   localparam int unsigned ALM_E1_UNAVAIL = 7;
   localparam int unsigned NUM_ALM = 8;

endpackage : lapm_pkg

// >>> lapm_line_model.sv
// Status source standing in for the E1 framer and the DSL transceiver.
// Assumes the bench calls its tasks just after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none
module lapm_line_model (
   input wire logic pclk, // System clock
   output logic [8:0] lv, // Levels: clkloss,rmt,loc,sync,lof,ais,yel,los,rai
   output logic dcrc, // DSL CRC-6 error pulse
   output logic ecrc, // E1 CRC error pulse
   output logic bipolar_violation_count, // E1 bipolar violation pulse
   output logic slip // E1 controlled slip pulse
);
   initial begin
      {lv, dcrc, ecrc, bipolar_violation_count, slip} = '0;
   end

   task automatic hold(input logic [8:0] l);
      lv <= l;
   endtask : hold

   // ------------------------------------------------------------------
   // One burst of n cycles; everything falls quiet before the second ends
   // ------------------------------------------------------------------
   task automatic run(input int d, e, b, s, input logic [8:0] l, input int n);
      for (int i = 0; i <= n; i++) begin
         lv <= (i < 10) ? l : 9'h000;
         dcrc <= i < d;
         ecrc <= i < e;
         bipolar_violation_count <= i < b;
         slip <= i < s;
         if (i < n) @(posedge pclk);
      end
   endtask : run
endmodule : lapm_line_model
`default_nettype wire

// >>> lapm_top_tb_top.sv
// Bench for lapm_top: alarms and counters read over APB and compared with
// values reckoned from the status that the line model drives.
// Assumes a second shortened to 2200 cycles, long enough for 2048 events.
`timescale 1ns/10ps
`default_nettype none
module lapm_top_tb_top;
   localparam int SC = 2200;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, second_strobe, dcrc, ecrc, bipolar_violation_count, slip;
   wire [6:0] alm;
   logic [8:0] lv;
   logic [32:0] exp_q[$];
   int err_count = 0;
   int comparisons = 0;
   int seed = 94921;
   int exp_cnt[9] = '{default: 0};
   int run = 0;
   logic unav = 1'b0;
   logic crc4 = 1'b1;
   logic ce = 1'b1;

   always #5 pclk = ~pclk;

   lapm_top #(.SECOND_CYCLES(SC)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .primary_clock_present(!lv[0]),
      .remote_ui_inactive(lv[1]), .local_ui_inactive(lv[2]), .dsl_sync_lost(lv[3]),
      .dsl_crc_error(dcrc), .e1_los(lv[7]), .e1_lof(lv[4]), .e1_ais(lv[5]), .e1_rai(lv[8]),
      .e1_yellow(lv[6]), .e1_slip(slip), .e1_bpv(bipolar_violation_count), .e1_crc_error(ecrc),
      .primary_clock_loss_alarm(alm[0]), .remote_link_alarm(alm[1]),
      .local_user_link_alarm(alm[2]), .dsl_loss_of_sync_alarm(alm[3]),
      .e1_loss_of_frame_alarm(alm[4]), .e1_ais_alarm(alm[5]), .far_end_yellow_alarm(alm[6]),
      .second_strobe(second_strobe));
   lapm_line_model model (.pclk(pclk), .lv(lv), .dcrc(dcrc), .ecrc(ecrc), .bipolar_violation_count(bipolar_violation_count),
      .slip(slip));

   // ------------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // Oldest note is matched to each completed transfer: {pslverr, prdata}
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         check("apb response", {pslverr, prdata}, exp_q.pop_front());
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic [32:0] e);
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic strobe();
      do begin
         @(posedge pclk);
      end while (second_strobe !== 1'b1);
   endtask : strobe

   // One second of traffic, expected tallies, then all counters read back;
   // seconds follow each other with no idle second so SEVERELY_ERRORED_SECONDS runs stay unbroken
   task automatic sec(input int d, e, b, s, input logic [8:0] l);
      logic es, severely_errored_seconds;
      model.run(d, e, b, s, l, SC - 100);
      es = l[4] | l[5] | l[7] | l[8] | (s > 0);
      severely_errored_seconds = es | (crc4 ? e >= 832 : b >= 2048);
      es = es | (crc4 ? e > 0 : b > 0);
      run = severely_errored_seconds ? run + 1 : 0;
      // Leaving unavailability is not modelled; the run ends while unavailable
      if (unav || run >= 10) begin
         unav = 1'b1;
         exp_cnt[4]++;
      end
      exp_cnt[0] += int'(l[3]);
      exp_cnt[1] += int'(d >= 150);
      exp_cnt[2] += int'(d > 0);
      exp_cnt[3] += d;
      exp_cnt[5] += int'(severely_errored_seconds);
      exp_cnt[6] += int'(es);
      exp_cnt[7] += b;
      exp_cnt[8] += e;
      strobe();
      for (int k = 0; k < 9; k++) apb(1'b0, 8'(8 + 4 * k), 32'h0, {1'b0, 32'(exp_cnt[k])});
   endtask : sec

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0, 33'h000000001);
      apb(1'b0, 8'h2C, 32'h0, 33'h100000000);
      for (int i = 0; i < 7; i++) begin
         model.hold(9'(1 << i));
         repeat (3) @(posedge pclk);
         check("alarm flags", {26'h0, alm}, 33'(1 << i));
         apb(1'b0, 8'h04, 32'h0, 33'(1 << i));
      end
      ce <= 1'b0;
      model.hold(9'h000);
      repeat (3) @(posedge pclk);
      check("alarm freeze", {26'h0, alm}, 33'h040);
      ce <= 1'b1;
      strobe();
      apb(1'b1, 8'h00, 32'h3, 33'h0);
      sec(149, 831, 0, 0, 9'h000);
      sec(150, 832, 0, 0, 9'h000);
      apb(1'b1, 8'h00, 32'h0, 33'h0);
      crc4 = 1'b0;
      apb(1'b0, 8'h00, 32'h0, 33'h0);
      sec(0, 5, 2047, 0, 9'h000);
      sec(0, 0, 2048, 0, 9'h000);
      sec(0, 0, 0, 1, 9'h000);
      for (int k = 3; k < 9; k++) if (k != 6) sec(0, 0, 0, 0, 9'(1 << k));
      repeat (3) sec({$random(seed)} % 300, {$random(seed)} % 900, {$random(seed)} % 2047, 0,
         9'h000);
      repeat (11) sec(0, 0, 0, 0, 9'h080);
      apb(1'b0, 8'h04, 32'h0, 33'h080);
      summarize();
   end

   initial begin
      #(SC * 10 * 35);
      err_count++;
      summarize();
   end
endmodule : lapm_top_tb_top
`default_nettype wire
